// [rtl/afti_defines.svh]
`ifndef AFTI_DEFINES_SVH
`define AFTI_DEFINES_SVH

// Register word indices (byte address is four times the index)
`define AFTI_IDX_CTRL 6'h00
`define AFTI_IDX_STATUS 6'h01
`define AFTI_IDX_MASK 6'h02
`define AFTI_IDX_POS 6'h03
`define AFTI_IDX_WORD 6'h04

// Control register fields
`define AFTI_CTRL_RUN 0
`define AFTI_CTRL_MASTER 1
`define AFTI_CTRL_RATE_LSB 2
`define AFTI_CTRL_RATE_MSB 5
`define AFTI_CTRL_W 6
`define AFTI_CTRL_RST 6'h00

// Status and mask bits
`define AFTI_ST_RFP 0
`define AFTI_ST_HFP 1
`define AFTI_ST_OVW 2
`define AFTI_ST_RESYNC 3
`define AFTI_ST_W 4
`define AFTI_ST_RST 4'h0

// Frame geometry
`define AFTI_HF_MAX 8'h95
`define AFTI_BF_MAX 8'hFF

// Line rate codes and word index maxima
`define AFTI_RATE_0G6 4'h0
`define AFTI_RATE_1G2 4'h1
`define AFTI_RATE_2G4 4'h2
`define AFTI_RATE_3G0 4'h3
`define AFTI_RATE_4G9 4'h4
`define AFTI_RATE_6G1 4'h5
`define AFTI_RATE_8G1 4'h6
`define AFTI_RATE_9G8 4'h7
`define AFTI_RATE_10G1 4'h8
`define AFTI_RATE_12G1_W64 4'h9
`define AFTI_RATE_24G3_W64 4'hA
`define AFTI_MAX_0G6 7'h03
`define AFTI_MAX_1G2 7'h07
`define AFTI_MAX_2G4 7'h0F
`define AFTI_MAX_3G0 7'h13
`define AFTI_MAX_4G9 7'h1F
`define AFTI_MAX_6G1 7'h27
`define AFTI_MAX_8G1 7'h3F
`define AFTI_MAX_9G8 7'h3F
`define AFTI_MAX_10G1 7'h4F
`define AFTI_MAX_12G1_W64 7'h2F
`define AFTI_MAX_24G3_W64 7'h5F

`endif

// [rtl/afti_frame_counter.sv]
`timescale 1ns/1ns
`include "afti_defines.svh"
module afti_frame_counter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic adv_i,
    input wire logic load_i,
    input wire logic [11:0] preset_i,
    input wire logic [6:0] word_max_i,
    afti_pos_if.src pos
);
    logic word_wrap;
    logic bf_wrap;
    logic hf_wrap;

    // Compare with >= so a rate lowered mid-frame still wraps
    assign word_wrap = pos.word >= word_max_i;
    assign bf_wrap = word_wrap && (pos.bf == `AFTI_BF_MAX);
    assign hf_wrap = bf_wrap && (pos.hf >= `AFTI_HF_MAX);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos.word <= 7'h00;
            pos.bf <= 8'h00;
            pos.hf <= 8'h00;
            pos.rfn <= 12'h000;
        end else if (load_i) begin
            pos.word <= 7'h00;
            pos.bf <= 8'h00;
            pos.hf <= 8'h00;
            pos.rfn <= preset_i;
        end else if (adv_i) begin
            pos.word <= word_wrap ? 7'h00 : 7'(pos.word + 7'h01);
            if (word_wrap) begin
                pos.bf <= 8'(pos.bf + 8'h01);
            end
            if (bf_wrap) begin
                pos.hf <= hf_wrap ? 8'h00 : 8'(pos.hf + 8'h01);
            end
            if (hf_wrap) begin
                pos.rfn <= 12'(pos.rfn + 12'h001);
            end
        end
    end

    // Pulses line up with the first word of the new frame
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos.rfp <= 1'b0;
            pos.hfp <= 1'b0;
        end else begin
            pos.rfp <= load_i || (adv_i && hf_wrap);
            pos.hfp <= load_i || (adv_i && bf_wrap);
        end
    end
endmodule

// [rtl/afti_pkg.sv]
package afti_pkg;
    typedef enum logic [1:0] {
        AFTI_HOLD = 2'b01,
        AFTI_RUN = 2'b10
    } afti_state_e;
    typedef logic [6:0] afti_word_t;
    typedef logic [11:0] afti_rfn_t;
endpackage

// [rtl/afti_pos_if.sv]
`timescale 1ns/1ns
interface afti_pos_if;
    afti_pkg::afti_word_t word;
    logic [7:0] bf;
    logic [7:0] hf;
    afti_pkg::afti_rfn_t rfn;
    logic rfp;
    logic hfp;
    modport src (output word, output bf, output hf, output rfn, output rfp, output hfp);
    modport dst (input word, input bf, input hf, input rfn, input rfp, input hfp);
endinterface

// [rtl/afti_rx_packer.sv]
`timescale 1ns/1ns
module afti_rx_packer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] byte_i,
    input wire logic byte_valid_i,
    input wire logic byte_ctrl_i,
    output logic [31:0] word_o,
    output logic [3:0] flags_o,
    output logic valid_o
);
    logic [1:0] lane_r;
    logic [23:0] hold_r;
    logic [2:0] hold_flags_r;
    logic last_lane;

    assign last_lane = byte_valid_i && (lane_r == 2'h3);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lane_r <= 2'h0;
        end else if (byte_valid_i) begin
            lane_r <= 2'(lane_r + 2'h1);
        end
    end

    // Earlier bytes shift toward the top lane
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_r <= 24'h000000;
            hold_flags_r <= 3'h0;
        end else if (byte_valid_i) begin
            hold_r <= {hold_r[15:0], byte_i};
            hold_flags_r <= {hold_flags_r[1:0], byte_ctrl_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_o <= 32'h00000000;
            flags_o <= 4'h0;
            valid_o <= 1'b0;
        end else begin
            valid_o <= last_lane;
            if (last_lane) begin
                word_o <= {hold_r, byte_i};
                flags_o <= {hold_flags_r, byte_ctrl_i};
            end
        end
    end

    property p_rx_last_byte;
        @(posedge clk_i) disable iff (rst_i)
        last_lane |=> valid_o && word_o[7:0] == $past(byte_i) && flags_o[0] == $past(byte_ctrl_i);
    endproperty
    a_rx_last_byte: assert property (p_rx_last_byte) else $error("rx last byte misplaced");

    // First lane captured apart from the shift chain, so a broken shift shows
    logic [7:0] first_byte_r;
    logic first_ctrl_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_byte_r <= 8'h00;
            first_ctrl_r <= 1'b0;
        end else if (byte_valid_i && lane_r == 2'h0) begin
            first_byte_r <= byte_i;
            first_ctrl_r <= byte_ctrl_i;
        end
    end

    property p_rx_first_byte;
        @(posedge clk_i) disable iff (rst_i)
        last_lane |=> valid_o && word_o[31:24] == $past(first_byte_r)
            && flags_o[3] == $past(first_ctrl_r);
    endproperty
    a_rx_first_byte: assert property (p_rx_first_byte) else $error("rx first flag misplaced");
endmodule

// [rtl/afti_top.sv]
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "afti_defines.svh"
module afti_top #(
    parameter int EXTRA_WR_LAT = 0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    input wire logic [7:0] rx_link_byte_i,
    input wire logic rx_link_byte_valid_i,
    input wire logic rx_link_byte_ctrl_i,
    output logic [31:0] aux_receive_word_o,
    output logic [3:0] aux_receive_ctrl_byte_flags_o,
    output logic aux_receive_word_valid_o,
    input wire logic radio_frame_resync_pulse_i,
    input wire logic [11:0] frame_number_preset_i,
    input wire logic [31:0] aux_transmit_word_i,
    input wire logic [31:0] insertion_bit_mask_i,
    input wire logic [31:0] tx_core_word_i,
    output logic [31:0] tx_frame_word_o,
    output logic [3:0] overwrite_error_flags_o,
    output logic tx_radio_frame_pulse_o,
    output logic tx_hyperframe_pulse_o,
    output logic [11:0] tx_radio_frame_number_o,
    output logic [7:0] tx_hyperframe_index_o,
    output logic [7:0] tx_basic_frame_index_o,
    output logic [6:0] tx_word_index_o
);
    localparam int LAT = EXTRA_WR_LAT + 1;

    // Word index maximum for the selected line rate
    function automatic logic [6:0] word_max(input logic [3:0] rate);
        logic [6:0] m;
        m = `AFTI_MAX_0G6;
        case (rate)
            `AFTI_RATE_0G6: m = `AFTI_MAX_0G6;
            `AFTI_RATE_1G2: m = `AFTI_MAX_1G2;
            `AFTI_RATE_2G4: m = `AFTI_MAX_2G4;
            `AFTI_RATE_3G0: m = `AFTI_MAX_3G0;
            `AFTI_RATE_4G9: m = `AFTI_MAX_4G9;
            `AFTI_RATE_6G1: m = `AFTI_MAX_6G1;
            `AFTI_RATE_8G1: m = `AFTI_MAX_8G1;
            `AFTI_RATE_9G8: m = `AFTI_MAX_9G8;
            `AFTI_RATE_10G1: m = `AFTI_MAX_10G1;
            `AFTI_RATE_12G1_W64: m = `AFTI_MAX_12G1_W64;
            `AFTI_RATE_24G3_W64: m = `AFTI_MAX_24G3_W64;
            default: m = `AFTI_MAX_0G6;
        endcase
        return m;
    endfunction

    // Control word is the first sixteenth of the basic frame's bytes
    function automatic logic [3:0] ctrl_lanes(input logic [6:0] word, input logic [6:0] max);
        logic [3:0] lanes;
        logic [8:0] limit;
        logic [8:0] first;
        lanes = 4'h0;
        limit = 9'(({2'h0, max} + 9'h001) >> 2);
        first = {word, 2'h0};
        for (int i = 0; i < 4; i++) begin
            lanes[3 - i] = 9'(first + 9'(i)) < limit;
        end
        return lanes;
    endfunction

    // Any masked bit in a lane counts as overwriting that lane
    function automatic logic [3:0] mask_lanes(input logic [31:0] mask);
        logic [3:0] lanes;
        lanes = 4'h0;
        for (int i = 0; i < 4; i++) begin
            lanes[i] = |mask[i * 8 +: 8];
        end
        return lanes;
    endfunction

    afti_pos_if pos ();

    afti_pkg::afti_state_e state_r;
    afti_pkg::afti_state_e state_nxt;
    logic [`AFTI_CTRL_W-1:0] ctrl_r;
    logic [`AFTI_ST_W-1:0] status_r;
    logic [`AFTI_ST_W-1:0] status_nxt;
    logic [`AFTI_ST_W-1:0] irq_mask_r;
    logic resync_prev_r;
    logic resync_rise;
    logic resync_load;
    logic [6:0] max_now;
    logic [3:0] ctrl_pipe_r [LAT];
    logic [3:0] ctrl_aligned;
    logic [3:0] ovw_nxt;
    logic wb_req;
    logic [5:0] wb_idx;
    logic [31:0] rd_data;

    assign max_now = word_max(ctrl_r[`AFTI_CTRL_RATE_MSB:`AFTI_CTRL_RATE_LSB]);
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_idx = wb_adr_i[7:2];

    // Edge detect keeps a held-high resync from restarting framing every cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            resync_prev_r <= 1'b0;
        end else begin
            resync_prev_r <= radio_frame_resync_pulse_i;
        end
    end
    assign resync_rise = radio_frame_resync_pulse_i && !resync_prev_r;
    assign resync_load = resync_rise && ctrl_r[`AFTI_CTRL_MASTER];

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            afti_pkg::AFTI_HOLD: begin
                if (ctrl_r[`AFTI_CTRL_RUN] || resync_load) begin
                    state_nxt = afti_pkg::AFTI_RUN;
                end
            end
            afti_pkg::AFTI_RUN: begin
                if (!ctrl_r[`AFTI_CTRL_RUN] && !resync_load) begin
                    state_nxt = afti_pkg::AFTI_HOLD;
                end
            end
            default: state_nxt = afti_pkg::AFTI_HOLD;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= afti_pkg::AFTI_HOLD;
        end else begin
            state_r <= state_nxt;
        end
    end

    afti_frame_counter u_counter (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .adv_i(state_r == afti_pkg::AFTI_RUN),
        .load_i(resync_load),
        .preset_i(frame_number_preset_i),
        .word_max_i(max_now),
        .pos(pos.src)
    );

    assign tx_word_index_o = pos.word;
    assign tx_basic_frame_index_o = pos.bf;
    assign tx_hyperframe_index_o = pos.hf;
    assign tx_radio_frame_number_o = pos.rfn;
    assign tx_radio_frame_pulse_o = pos.rfp;
    assign tx_hyperframe_pulse_o = pos.hfp;

    afti_rx_packer u_rx (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .byte_i(rx_link_byte_i),
        .byte_valid_i(rx_link_byte_valid_i),
        .byte_ctrl_i(rx_link_byte_ctrl_i),
        .word_o(aux_receive_word_o),
        .flags_o(aux_receive_ctrl_byte_flags_o),
        .valid_o(aux_receive_word_valid_o)
    );

    // Control lanes follow the word index by the write latency
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < LAT; i++) begin
                ctrl_pipe_r[i] <= 4'h0;
            end
        end else begin
            ctrl_pipe_r[0] <= ctrl_lanes(pos.word, max_now);
            for (int i = 1; i < LAT; i++) begin
                ctrl_pipe_r[i] <= ctrl_pipe_r[i - 1];
            end
        end
    end
    assign ctrl_aligned = ctrl_pipe_r[LAT - 1];
    assign ovw_nxt = ctrl_aligned & mask_lanes(insertion_bit_mask_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_frame_word_o <= 32'h00000000;
            overwrite_error_flags_o <= 4'h0;
        end else begin
            tx_frame_word_o <= (aux_transmit_word_i & insertion_bit_mask_i)
                | (tx_core_word_i & ~insertion_bit_mask_i);
            overwrite_error_flags_o <= ovw_nxt;
        end
    end

    // Status read clears, but a same-cycle event still lands
    always_comb begin
        status_nxt = status_r;
        if (wb_req && !wb_we_i && wb_idx == `AFTI_IDX_STATUS) begin
            status_nxt = `AFTI_ST_RST;
        end
        if (pos.rfp) begin
            status_nxt[`AFTI_ST_RFP] = 1'b1;
        end
        if (pos.hfp) begin
            status_nxt[`AFTI_ST_HFP] = 1'b1;
        end
        if (|ovw_nxt) begin
            status_nxt[`AFTI_ST_OVW] = 1'b1;
        end
        if (resync_load) begin
            status_nxt[`AFTI_ST_RESYNC] = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_r <= `AFTI_ST_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(status_r & irq_mask_r);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `AFTI_CTRL_RST;
            irq_mask_r <= `AFTI_ST_RST;
        end else if (wb_req && wb_we_i && wb_sel_i[0]) begin
            if (wb_idx == `AFTI_IDX_CTRL) begin
                ctrl_r <= wb_dat_i[`AFTI_CTRL_W-1:0];
            end
            if (wb_idx == `AFTI_IDX_MASK) begin
                irq_mask_r <= wb_dat_i[`AFTI_ST_W-1:0];
            end
        end
    end

    always_comb begin
        case (wb_idx)
            `AFTI_IDX_CTRL: rd_data = {26'h0, ctrl_r};
            `AFTI_IDX_STATUS: rd_data = {28'h0000000, status_r};
            `AFTI_IDX_MASK: rd_data = {28'h0000000, irq_mask_r};
            `AFTI_IDX_POS: rd_data = {4'h0, pos.rfn, pos.hf, pos.bf};
            `AFTI_IDX_WORD: rd_data = {25'h0, pos.word};
            default: rd_data = 32'h00000000;
        endcase
    end

    // One wait state; unmapped reads return zero and writes are dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

    property p_resync_zero;
        @(posedge clk_i) disable iff (rst_i)
        resync_load |=> tx_basic_frame_index_o == 8'h00 && tx_word_index_o == 7'h00;
    endproperty
    a_resync_zero: assert property (p_resync_zero) else $error("resync did not zero index");

    property p_resync_frame;
        @(posedge clk_i) disable iff (rst_i)
        resync_load |=> tx_radio_frame_pulse_o && tx_hyperframe_index_o == 8'h00;
    endproperty
    a_resync_frame: assert property (p_resync_frame) else $error("resync did not start frame");

    property p_preset;
        @(posedge clk_i) disable iff (rst_i)
        resync_load |=> tx_radio_frame_number_o == $past(frame_number_preset_i);
    endproperty
    a_preset: assert property (p_preset) else $error("preset not loaded");

    property p_level_ignored;
        @(posedge clk_i) disable iff (rst_i)
        radio_frame_resync_pulse_i && resync_prev_r && state_r == afti_pkg::AFTI_RUN
            && tx_word_index_o < max_now |=> tx_word_index_o == 7'($past(tx_word_index_o) + 7'h01);
    endproperty
    a_level_ignored: assert property (p_level_ignored) else $error("held resync restarted");

    property p_word_wrap;
        @(posedge clk_i) disable iff (rst_i)
        state_r == afti_pkg::AFTI_RUN && !resync_load && tx_word_index_o >= max_now
            |=> tx_word_index_o == 7'h00
            && tx_basic_frame_index_o == 8'($past(tx_basic_frame_index_o) + 8'h01);
    endproperty
    a_word_wrap: assert property (p_word_wrap) else $error("word index wrap wrong");

    property p_hf_range;
        @(posedge clk_i) disable iff (rst_i)
        tx_hyperframe_index_o <= `AFTI_HF_MAX;
    endproperty
    a_hf_range: assert property (p_hf_range) else $error("hyperframe index out of range");

    property p_rfn_step;
        @(posedge clk_i) disable iff (rst_i)
        state_r == afti_pkg::AFTI_RUN && !resync_load && tx_word_index_o >= max_now
            && tx_basic_frame_index_o == `AFTI_BF_MAX && tx_hyperframe_index_o == `AFTI_HF_MAX
            |=> tx_hyperframe_index_o == 8'h00
            && tx_radio_frame_number_o == 12'($past(tx_radio_frame_number_o) + 12'h001);
    endproperty
    a_rfn_step: assert property (p_rfn_step) else $error("frame number did not advance");

    property p_rfp_position;
        @(posedge clk_i) disable iff (rst_i)
        tx_radio_frame_pulse_o |-> tx_hyperframe_pulse_o && tx_hyperframe_index_o == 8'h00
            && tx_basic_frame_index_o == 8'h00 && tx_word_index_o == 7'h00;
    endproperty
    a_rfp_position: assert property (p_rfp_position) else $error("radio frame pulse misplaced");

    property p_hfp_position;
        @(posedge clk_i) disable iff (rst_i)
        tx_hyperframe_pulse_o |-> tx_basic_frame_index_o == 8'h00 && tx_word_index_o == 7'h00;
    endproperty
    a_hfp_position: assert property (p_hfp_position) else $error("hyperframe pulse misplaced");

    property p_ovw_flag;
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> overwrite_error_flags_o
            == ($past(ctrl_aligned) & $past(mask_lanes(insertion_bit_mask_i)));
    endproperty
    a_ovw_flag: assert property (p_ovw_flag) else $error("overwrite flag wrong");
endmodule

// [verification/afti_top_tb.sv]
`timescale 1ns/1ns
module afti_top_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic [7:0] rxb = 8'h00;
    logic rxv = 1'b0;
    logic rxc = 1'b0;
    logic sync = 1'b0;
    logic [11:0] preset = 12'h000;
    logic bad = 1'b0;
    logic [31:0] rdat, aux, mask, rxw, q, txw;
    logic [3:0] rxf, err;
    logic ack, irq, rxok, rfp, hfp;
    logic [11:0] rfn;
    logic [7:0] hf, bf;
    logic [6:0] wi;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;

    always #25 clk_i = ~clk_i;

    afti_top #(.EXTRA_WR_LAT(0)) afti_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
        .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack),
        .irq_o(irq), .rx_link_byte_i(rxb), .rx_link_byte_valid_i(rxv),
        .rx_link_byte_ctrl_i(rxc), .aux_receive_word_o(rxw),
        .aux_receive_ctrl_byte_flags_o(rxf), .aux_receive_word_valid_o(rxok),
        .radio_frame_resync_pulse_i(sync), .frame_number_preset_i(preset),
        .aux_transmit_word_i(aux), .insertion_bit_mask_i(mask),
        .tx_core_word_i(32'h0F0F0F0F),
        .tx_frame_word_o(txw), .overwrite_error_flags_o(err), .tx_radio_frame_pulse_o(rfp),
        .tx_hyperframe_pulse_o(hfp), .tx_radio_frame_number_o(rfn),
        .tx_hyperframe_index_o(hf), .tx_basic_frame_index_o(bf), .tx_word_index_o(wi)
    );

    afti_user_model afti_user_model_inst (
        .clk_i(clk_i), .rst_i(rst_i), .word_i(wi), .bad_i(bad),
        .aux_word_o(aux), .mask_o(mask)
    );

    task conclude;
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Ceiling sized well above the roughly 4000 cycles the sequence needs
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 10000) begin
            n_fail++;
            conclude;
        end
    end

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task do_reset(input int n);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (n) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    task t_regs;
        wb(8'h00, 1'b0, 32'h0);
        chk("ctrl reset", 32'h0, q);
        wb(8'h00, 1'b1, 32'hFFFFFFFF);
        wb(8'h00, 1'b0, 32'h0);
        chk("ctrl rw", 32'h3F, q);
        wb(8'h08, 1'b1, 32'hFFFFFFFF);
        wb(8'h08, 1'b0, 32'h0);
        chk("mask rw", 32'hF, q);
        wb(8'h14, 1'b1, 32'hFFFFFFFF);
        wb(8'h14, 1'b0, 32'h0);
        chk("unmapped", 32'h0, q);
        do_reset(2);
    endtask

    task rx_word(input logic [31:0] w, input logic [3:0] c);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk_i);
            rxb <= w[31 - 8 * i -: 8];
            rxv <= 1'b1;
            rxc <= c[3 - i];
        end
        @(posedge clk_i);
        rxv <= 1'b0;
        #1;
        chk("rx word", w, rxw);
        chk("rx flags", {28'h0, c}, {28'h0, rxf});
        chk("rx valid", 32'h1, {31'h0, rxok});
    endtask

    task t_rates;
        logic [6:0] mx [12] = '{7'h03, 7'h07, 7'h0F, 7'h13, 7'h1F, 7'h27, 7'h3F, 7'h3F,
            7'h4F, 7'h2F, 7'h5F, 7'h03};
        logic [6:0] top, pw;
        logic [7:0] pb;
        // Last entry is an undefined rate code, which falls back to the slowest maximum
        for (int r = 0; r < 12; r++) begin
            do_reset(2);
            wb(8'h00, 1'b1, {26'h0, r[3:0], 2'b01});
            repeat (3) @(posedge clk_i);
            pw = wi;
            pb = bf;
            top = 7'h00;
            repeat (200) begin
                @(posedge clk_i);
                if (r == 0) begin
                    chk("word step", (pw == 7'h03) ? 32'h0 : pw + 32'h1, {25'h0, wi});
                    chk("bf step", (pw == 7'h03) ? pb + 32'h1 : pb, {24'h0, bf});
                end
                pw = wi;
                pb = bf;
                if (wi > top)
                    top = wi;
            end
            chk("word max", {25'h0, mx[r]}, {25'h0, top});
        end
    endtask

    task t_resync;
        do_reset(2);
        wb(8'h00, 1'b1, 32'h3);
        wb(8'h04, 1'b0, 32'h0);
        repeat (5) @(posedge clk_i);
        preset <= 12'hABC;
        sync <= 1'b1;
        @(posedge clk_i);
        preset <= 12'h123;
        #1;
        chk("resync pos", {4'h0, 12'hABC, 16'h0}, {4'h0, rfn, hf, bf});
        chk("resync pulses", 32'h3, {23'h0, wi, rfp, hfp});
        repeat (3) @(posedge clk_i);
        sync <= 1'b0;
        #1;
        chk("held level", {13'h0, 7'h03, 12'hABC}, {13'h0, wi, rfn});
        // Four words times 256 basic frames per hyperframe at the slowest rate
        repeat (1021) @(posedge clk_i);
        #1;
        chk("hf wrap", {8'h0, 8'h01, 16'h0}, {8'h0, hf, bf, 1'b0, wi});
        chk("hf pulses", 32'h1, {30'h0, rfp, hfp});
        wb(8'h08, 1'b1, 32'h2);
        repeat (2) @(posedge clk_i);
        #1;
        chk("irq set", 32'h1, {31'h0, irq});
        wb(8'h04, 1'b0, 32'h0);
        chk("status", 32'hB, q);
        repeat (2) @(posedge clk_i);
        #1;
        chk("irq clear", 32'h0, {31'h0, irq});
    endtask

    task t_ovw;
        int n;
        logic [3:0] seen;
        logic [31:0] e;
        n = 0;
        @(posedge clk_i);
        bad <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (err === 4'h0 && n < 20);
        chk("err flags", 32'h8, {28'h0, err});
        bad <= 1'b0;
        repeat (2) @(posedge clk_i);
        seen = 4'h0;
        // Control word cycles pass the core word, the others the user word
        repeat (12) begin
            @(posedge clk_i);
            e = (aux & mask) | (32'h0F0F0F0F & ~mask);
            seen = seen | err;
            #1;
            chk("tx word", e, txw);
        end
        chk("err clean", 32'h0, {28'h0, seen});
        wb(8'h04, 1'b0, 32'h0);
        chk("status ovw", 32'h4, q & 32'h4);
    endtask

    initial begin
        do_reset(20);
        t_regs;
        rx_word(32'hA1B2C3D4, 4'hC);
        rx_word(32'h0F1E2D3C, 4'h1);
        t_rates;
        t_resync;
        t_ovw;
        conclude;
    end
endmodule

// [verification/afti_user_model.sv]
`timescale 1ns/1ns
module afti_user_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [6:0] word_i,
    input wire logic bad_i,
    output logic [31:0] aux_word_o,
    output logic [31:0] mask_o
);
    // One cycle behind the index, matching zero extra write latency
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_word_o <= 32'h0;
            mask_o <= 32'h0;
        end else begin
            aux_word_o <= {1'b0, word_i, 24'h5A5A5A};
            // Word zero carries control bytes; only a deliberate fault masks it
            mask_o <= (word_i != 7'h00 || bad_i) ? 32'hFFFFFFFF : 32'h0;
        end
    end
endmodule
